//--- src/eew_pkg.sv
// constants and types shared by both ends of the eeprom write and lock link
package eew_pkg;
   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_DATA_HI      = 4'hB;
   localparam logic [7:0] CMD_OFFSET       = 8'hD3;
   localparam logic [7:0] CMD_ERASE        = 8'hD4;
   localparam logic [7:0] CMD_PASSWORD     = 8'hD5;
   localparam logic [7:0] CMD_STORE_USER   = 8'h15;
   localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
   localparam logic [7:0] CMD_RESTORE_FACT = 8'h12;
   // ----------------------------------------------------------------
   // array layout
   // ----------------------------------------------------------------
   localparam int         MAIN_AW       = 13;
   localparam int         PAGE_AW       = 9;
   localparam int         FIRST_FLAG_BLOCK_BYTES    = 128;
   localparam int         MAIN_BYTES    = 8192;
   localparam logic [3:0] PAGE_FACTORY  = 4'h0;
   localparam logic [3:0] PAGE_USER     = 4'h1;
   localparam logic [3:0] PAGE_INTERNAL = 4'h2;
   localparam logic [3:0] PAGE_FREE_LO  = 4'h4;
   localparam logic [7:0] PAGE_FREE_HI  = 8'h0F;
   localparam logic [7:0] ERASED_BYTE   = 8'hFF;
   localparam logic [8:0] PAGE_LAST     = 9'h1FF;
   localparam logic [8:0] MAX_BLOCK     = 9'h100;
   localparam logic [8:0] OFFSET_BYTES  = 9'h002;
   // ----------------------------------------------------------------
   // password, status, configuration
   // ----------------------------------------------------------------
   localparam logic [7:0]  PW_DEFAULT      = 8'hFF;
   localparam logic [15:0] STATUS_REG_ADDR = 16'hFEC3;
   localparam int          UNLOCK_BIT      = 4;
   localparam int          CFG_BYTES       = 16;
   localparam logic [8:0]  CFG_LAST        = 9'h00F;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned ERASE_TIME_MS  = 35;
   localparam int unsigned CLK_FREQ_KHZ   = 125000;
   localparam int unsigned ERASE_WAIT_CYC = ERASE_TIME_MS * CLK_FREQ_KHZ;
   localparam int          WAIT_W         = 23;
   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_XFER  = 2'b01,
      ST_ERASE = 2'b10,
      ST_LOAD  = 2'b11
   } eew_dev_st_e;
   typedef enum logic [1:0]
   {
      H_READY = 2'b00,
      H_ACK   = 2'b01,
      H_GUARD = 2'b10
   } eew_host_st_e;
endpackage

//--- src/eew_link_if.sv
// byte-level command link between the eeprom controller and its host
interface eew_link_if;
   logic       lk_start;
   logic       lk_data_stb;
   logic       lk_stop;
   logic [7:0] lk_byte;
   logic       lk_ack;
   logic       lk_nack;
   logic       lk_busy;
   modport dev
   (
      input  lk_start, lk_data_stb, lk_stop, lk_byte,
      output lk_ack, lk_nack, lk_busy
   );
   modport host
   (
      input  lk_ack, lk_nack, lk_busy,
      output lk_start, lk_data_stb, lk_stop, lk_byte
   );
endinterface

//--- src/eew_dev.sv
// eeprom controller write side: page writes, erase, password lock, settings restore
module eew_dev
   import eew_pkg::*;
(
   input  wire logic                   clk,           // 125 MHz clock
   input  wire logic                   reset,         // synchronous, active high
   eew_link_if.dev                     lk,            // command link from the host
   input  wire logic                   int_we,        // internal write strobe
   input  wire logic                   int_main,      // 1: main block, 0: first flag block
   input  wire logic [MAIN_AW-1:0]     int_addr,      // internal write address
   input  wire logic [7:0]             int_wdata,     // internal write data
   output logic      [8*CFG_BYTES-1:0] cfg_ff,        // configuration registers
   output logic      [7:0]             status_ff,     // status byte, unlocked in bit 4
   output logic      [15:0]            first_flag_ff  // first two first flag bytes
);
   // ----------------------------------------------------------------
   // storage and state
   // ----------------------------------------------------------------
   logic [7:0]         main_mem [MAIN_BYTES];
   logic [7:0]         first_flag_block_mem [FIRST_FLAG_BLOCK_BYTES];
   eew_dev_st_e        state_ff;
   logic [7:0]         cmd_ff;
   logic               cmd_ok_ff;
   logic [8:0]         nbytes_ff;
   logic [3:0]         page_ff;
   logic [8:0]         idx_ff;
   logic               erase_req_ff;
   logic [7:0]         off_hi_ff;
   logic [8:0]         offset_ff;
   logic [7:0]         pw_ff;
   logic               pw_ok_ff;
   logic               unlocked_ff;
   logic               code_known;
   logic               is_data;
   logic               byte_ok;
   logic               byte_ev;
   logic               pw_ev;
   logic [MAIN_AW-1:0] wr_addr;
   logic [MAIN_AW-1:0] work_addr;
   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   always_comb
   begin
      is_data    = (cmd_ff[7:4] == CMD_DATA_HI);
      code_known = (lk.lk_byte[7:4] == CMD_DATA_HI) || (lk.lk_byte == CMD_OFFSET)
                   || (lk.lk_byte == CMD_ERASE) || (lk.lk_byte == CMD_PASSWORD)
                   || (lk.lk_byte == CMD_RESTORE_USER) || (lk.lk_byte == CMD_RESTORE_FACT);
      byte_ev    = lk.lk_data_stb && (state_ff == ST_XFER);
      pw_ev      = byte_ev && cmd_ok_ff && (cmd_ff == CMD_PASSWORD) && (nbytes_ff == '0);
      // page from the low nibble, position wraps inside the page
      wr_addr    = {cmd_ff[3:0], PAGE_AW'(offset_ff + nbytes_ff)};
      work_addr  = {page_ff, idx_ff};
      byte_ok    = 1'b0;
      if (cmd_ok_ff)
      begin
         if (is_data)
            // locked, factory/user page or overlong block: refused
            byte_ok = (cmd_ff[3:0] >= PAGE_INTERNAL) && unlocked_ff
                      && (nbytes_ff < MAX_BLOCK);
         else if (cmd_ff == CMD_OFFSET)
            byte_ok = (nbytes_ff < OFFSET_BYTES);
         else if (cmd_ff == CMD_ERASE)
            byte_ok = (nbytes_ff == '0) && unlocked_ff && (lk.lk_byte >= 8'(PAGE_FREE_LO))
                      && (lk.lk_byte <= PAGE_FREE_HI);
         else if (cmd_ff == CMD_PASSWORD)
            byte_ok = (nbytes_ff == '0);
         else
            byte_ok = 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // transaction and sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_ff     <= ST_LOAD;
         page_ff      <= PAGE_USER;
         idx_ff       <= '0;
         cmd_ff       <= '0;
         cmd_ok_ff    <= 1'b0;
         nbytes_ff    <= '0;
         erase_req_ff <= 1'b0;
      end
      else
      begin
         case (state_ff)
            ST_IDLE:
            begin
               if (lk.lk_start)
               begin
                  state_ff     <= ST_XFER;
                  cmd_ff       <= lk.lk_byte;
                  cmd_ok_ff    <= code_known;
                  nbytes_ff    <= '0;
                  erase_req_ff <= 1'b0;
               end
            end
            ST_XFER:
            begin
               if (lk.lk_data_stb && (nbytes_ff != PAGE_LAST))
                  nbytes_ff <= nbytes_ff + 9'h001;
               if (byte_ev && byte_ok && (cmd_ff == CMD_ERASE))
               begin
                  erase_req_ff <= 1'b1;
                  page_ff      <= lk.lk_byte[3:0];
               end
               if (lk.lk_stop)
               begin
                  idx_ff <= '0;
                  if (cmd_ok_ff && (nbytes_ff == '0) && (cmd_ff == CMD_RESTORE_USER))
                  begin
                     state_ff <= ST_LOAD;
                     page_ff  <= PAGE_USER;
                  end
                  else if (cmd_ok_ff && (nbytes_ff == '0) && (cmd_ff == CMD_RESTORE_FACT))
                  begin
                     state_ff <= ST_LOAD;
                     page_ff  <= PAGE_FACTORY;
                  end
                  else if (erase_req_ff)
                     state_ff <= ST_ERASE;
                  else
                     state_ff <= ST_IDLE;
               end
            end
            ST_ERASE:
            begin
               idx_ff <= idx_ff + 9'h001;
               if (idx_ff == PAGE_LAST)
                  state_ff <= ST_IDLE;
            end
            ST_LOAD:
            begin
               idx_ff <= idx_ff + 9'h001;
               if (idx_ff == CFG_LAST)
                  state_ff <= ST_IDLE;
            end
            default:
               state_ff <= ST_IDLE;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // link answers
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         lk.lk_ack  <= 1'b0;
         lk.lk_nack <= 1'b0;
         lk.lk_busy <= 1'b1;
      end
      else
      begin
         lk.lk_ack  <= lk.lk_start || lk.lk_data_stb;
         if (lk.lk_start)
            lk.lk_nack <= !((state_ff == ST_IDLE) && code_known);
         else if (lk.lk_data_stb)
            lk.lk_nack <= !(byte_ev && byte_ok);
         else
            lk.lk_nack <= 1'b0;
         lk.lk_busy <= (state_ff == ST_ERASE) || (state_ff == ST_LOAD);
      end
   end
   // ----------------------------------------------------------------
   // address offset, two bytes msb first
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         off_hi_ff <= '0;
         offset_ff <= '0;
      end
      else if (byte_ev && byte_ok && (cmd_ff == CMD_OFFSET))
      begin
         if (nbytes_ff == '0)
            off_hi_ff <= lk.lk_byte;
         else
            offset_ff <= {off_hi_ff[0], lk.lk_byte};
      end
   end
   // ----------------------------------------------------------------
   // password and lock
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pw_ff       <= PW_DEFAULT;
         pw_ok_ff    <= 1'b0;
         unlocked_ff <= 1'b0;
      end
      else if (pw_ev)
      begin
         if (lk.lk_byte == pw_ff)
         begin
            pw_ok_ff <= 1'b1;
            if (pw_ok_ff)
               unlocked_ff <= 1'b1;
         end
         else if (unlocked_ff && pw_ok_ff)
         begin
            pw_ff    <= lk.lk_byte;
            pw_ok_ff <= 1'b0;
         end
         else
         begin
            unlocked_ff <= 1'b0;
            pw_ok_ff    <= 1'b0;
         end
      end
      else if (lk.lk_stop && (state_ff == ST_XFER) && cmd_ok_ff && (nbytes_ff == '0)
               && (cmd_ff == CMD_RESTORE_FACT))
         pw_ff <= PW_DEFAULT;
      else if (lk.lk_start && (state_ff == ST_IDLE) && (lk.lk_byte != CMD_PASSWORD))
         pw_ok_ff <= 1'b0;
   end
   // ----------------------------------------------------------------
   // array writes: link programming only clears bits, erase sets them, internal writes overwrite
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (byte_ev && byte_ok && is_data)
         main_mem[wr_addr] <= main_mem[wr_addr] & lk.lk_byte;
      else if (state_ff == ST_ERASE)
         main_mem[work_addr] <= ERASED_BYTE;
      else if (int_we && int_main)
         main_mem[int_addr] <= int_wdata;
      // first flag block is reached only from the internal port
      if (int_we && !int_main)
         first_flag_block_mem[int_addr[6:0]] <= int_wdata;
   end
   // ----------------------------------------------------------------
   // configuration download
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
         cfg_ff <= '0;
      else if (state_ff == ST_LOAD)
         cfg_ff[8*idx_ff[3:0] +: 8] <= main_mem[work_addr];
   end
   // ----------------------------------------------------------------
   // status
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         status_ff     <= '0;
         first_flag_ff <= '0;
      end
      else
      begin
         status_ff             <= '0;
         status_ff[UNLOCK_BIT] <= unlocked_ff;
         first_flag_ff         <= {first_flag_block_mem[1], first_flag_block_mem[0]};
      end
   end
endmodule

//--- src/eew_host.sv
// host end: paces user bytes onto the eeprom command link
module eew_host
   import eew_pkg::*;
#(
   parameter int unsigned ERASE_WAIT = ERASE_WAIT_CYC  // cycles held after a page erase
)
(
   input  wire logic       clk,         // 125 MHz clock
   input  wire logic       reset,       // synchronous, active high
   eew_link_if.host        lk,          // command link to the device
   input  wire logic       u_valid,     // user byte offered
   input  wire logic       u_first,     // byte is a command code
   input  wire logic       u_last,      // byte ends the transaction
   input  wire logic [7:0] u_byte,      // user byte
   input  wire logic       dev_unlocked,// device unlocked status bit
   output logic            u_ready_ff,  // byte taken when valid and ready
   output logic            u_nack_ff,   // a nack was seen in this transaction
   output logic            u_err_ff,    // byte refused locally, one cycle
   output logic            u_done_ff    // transaction finished, one cycle
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   eew_host_st_e      state_ff;
   logic [7:0]        cmd_ff;
   logic [8:0]        cnt_ff;
   logic              open_ff;
   logic              last_ff;
   logic              stop_d_ff;
   logic [WAIT_W-1:0] wait_ff;
   logic              take;
   logic              bad_cmd;
   logic              bad_data;
   always_comb
   begin
      take     = u_valid && u_ready_ff;
      // reserved pages, or free pages while locked, are never written
      bad_cmd  = (u_byte[7:4] == CMD_DATA_HI) && ((u_byte[3:0] < PAGE_FREE_LO)
                 || !dev_unlocked);
      bad_data = !open_ff || ((cmd_ff[7:4] == CMD_DATA_HI) && (cnt_ff == MAX_BLOCK));
   end
   // ----------------------------------------------------------------
   // stop echo: the device's busy answer shows two edges after stop
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
         stop_d_ff <= 1'b0;
      else
         stop_d_ff <= lk.lk_stop;
   end
   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_ff       <= H_READY;
         u_ready_ff     <= 1'b0;
         u_nack_ff      <= 1'b0;
         u_err_ff       <= 1'b0;
         u_done_ff      <= 1'b0;
         cmd_ff         <= '0;
         cnt_ff         <= '0;
         open_ff        <= 1'b0;
         last_ff        <= 1'b0;
         wait_ff        <= '0;
         lk.lk_start    <= 1'b0;
         lk.lk_data_stb <= 1'b0;
         lk.lk_stop     <= 1'b0;
         lk.lk_byte     <= '0;
      end
      else
      begin
         lk.lk_start    <= 1'b0;
         lk.lk_data_stb <= 1'b0;
         lk.lk_stop     <= 1'b0;
         u_err_ff       <= 1'b0;
         u_done_ff      <= 1'b0;
         case (state_ff)
            H_READY:
            begin
               // a transaction opens only once the device is idle
               u_ready_ff <= open_ff || !lk.lk_busy;
               if (take)
               begin
                  u_ready_ff <= 1'b0;
                  if (u_first && !open_ff && !bad_cmd && !lk.lk_busy)
                  begin
                     lk.lk_start <= 1'b1;
                     lk.lk_byte  <= u_byte;
                     cmd_ff      <= u_byte;
                     cnt_ff      <= '0;
                     open_ff     <= 1'b1;
                     last_ff     <= u_last;
                     u_nack_ff   <= 1'b0;
                     state_ff    <= H_ACK;
                  end
                  else if (!u_first && !bad_data)
                  begin
                     lk.lk_data_stb <= 1'b1;
                     lk.lk_byte     <= u_byte;
                     cnt_ff         <= cnt_ff + 9'h001;
                     last_ff        <= u_last;
                     state_ff       <= H_ACK;
                  end
                  else
                     u_err_ff <= 1'b1;
               end
            end
            H_ACK:
            begin
               if (lk.lk_ack)
               begin
                  if (lk.lk_nack)
                     u_nack_ff <= 1'b1;
                  if (last_ff)
                  begin
                     lk.lk_stop <= 1'b1;
                     open_ff    <= 1'b0;
                     // erase needs its full time before anything else
                     wait_ff    <= (cmd_ff == CMD_ERASE || cmd_ff == CMD_STORE_USER)
                                   ? WAIT_W'(ERASE_WAIT) : '0;
                     state_ff   <= H_GUARD;
                  end
                  else
                  begin
                     u_ready_ff <= 1'b1;
                     state_ff   <= H_READY;
                  end
               end
            end
            H_GUARD:
            begin
               if (wait_ff != '0)
                  wait_ff <= wait_ff - WAIT_W'(1);
               else if (!lk.lk_busy && !lk.lk_stop && !stop_d_ff)
               begin
                  u_done_ff  <= 1'b1;
                  u_ready_ff <= 1'b1;
                  state_ff   <= H_READY;
               end
            end
            default:
               state_ff <= H_READY;
         endcase
      end
   end
endmodule

//--- bench/eew_link_properties.sv
// link checker for the eeprom write and lock block
module eew_link_properties
   import eew_pkg::*;
(
   input wire logic       clk,         // clock
   input wire logic       reset,       // sync reset
   input wire logic       lk_start,    // command strobe
   input wire logic       lk_data_stb, // data strobe
   input wire logic       lk_stop,     // close strobe
   input wire logic [7:0] lk_byte,     // link byte
   input wire logic       lk_ack,      // answer
   input wire logic       lk_nack,     // refusal
   input wire logic       lk_busy      // device busy
);
   logic [7:0] cmd_ff;
   logic [8:0] cnt_ff;
   logic       ok_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   always_ff @(posedge clk)
   begin
      if (lk_start)
         cmd_ff <= lk_byte;
   end
   // data bytes seen so far in the open transaction
   always_ff @(posedge clk)
   begin
      if (lk_start)
         cnt_ff <= 9'h000;
      else if (lk_data_stb && cnt_ff != 9'h1FF)
         cnt_ff <= cnt_ff + 9'h001;
   end
   // erase byte was accepted
   always_ff @(posedge clk)
   begin
      if (lk_start)
         ok_ff <= 1'b0;
      else if (lk_ack && !lk_nack && cmd_ff == CMD_ERASE && cnt_ff != 9'h000)
         ok_ff <= 1'b1;
   end
   ack_follows_a: assert property ((lk_start || lk_data_stb) |=> lk_ack)
      else $error("no ack after strobe");
   ack_cause_a: assert property (lk_ack |-> $past(lk_start) || $past(lk_data_stb))
      else $error("ack without strobe");
   nack_in_ack_a: assert property (lk_nack |-> lk_ack)
      else $error("nack outside ack cycle");
   page_low_nack_a: assert property (lk_data_stb && cmd_ff[7:4] == CMD_DATA_HI && cmd_ff[3:1] == 3'b000
      |=> lk_nack) else $error("write to page 0 or 1 taken");
   erase_range_a: assert property (lk_data_stb && cmd_ff == CMD_ERASE
      && (lk_byte < 8'h04 || lk_byte > PAGE_FREE_HI) |=> lk_nack) else $error("bad erase page taken");
   offset_len_a: assert property (lk_data_stb && cmd_ff == CMD_OFFSET && cnt_ff >= 9'h002 |=> lk_nack)
      else $error("third offset byte taken");
   block_len_a: assert property (lk_data_stb && cmd_ff[7:4] == CMD_DATA_HI && cnt_ff >= MAX_BLOCK
      |=> lk_nack) else $error("block byte beyond limit taken");
   erase_busy_a: assert property (lk_stop && ok_ff && cmd_ff == CMD_ERASE |-> ##2 lk_busy [*8])
      else $error("erase not busy");
   restore_busy_a: assert property (lk_stop && cnt_ff == 9'h000
      && (cmd_ff == CMD_RESTORE_USER || cmd_ff == CMD_RESTORE_FACT) |-> ##2 lk_busy [*8]) else $error("no download");
   powerup_busy_a: assert property ($fell(reset) |-> lk_busy [*8])
      else $error("no download after reset");
endmodule

//--- bench/tb_top.sv
// self-checking bench joining host and device ends of the eeprom link
module tb_top
   import eew_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed
   {
      logic [2:0]  n;
      logic [31:0] by;
      logic        nk;
      logic        er;
      logic        ul;
   } eew_row_s;
   logic                   clk;
   logic                   reset;
   logic                   u_valid, u_first, u_last;
   logic [7:0]             u_byte;
   logic                   int_we, int_main;
   logic [MAIN_AW-1:0]     int_addr;
   logic [7:0]             int_wdata;
   logic [8*CFG_BYTES-1:0] cfg_ff;
   logic [7:0]             status_ff;
   logic [15:0]            first_flag_ff;
   logic                   u_ready_ff, u_nack_ff, u_err_ff, u_done_ff;
   logic                   nk, er;
   logic [7:0]             bq[$];
   int                     miscompares;
   int                     tests_run;
   // bytes left-justified: count, bytes, nack, local refusal, unlocked after
   eew_row_s rows [20] = '{
      '{3'd1, 32'hB900_0000, 1'b0, 1'b1, 1'b0}, '{3'd2, 32'hD40A_0000, 1'b1, 1'b0, 1'b0},
      '{3'd2, 32'hD5FF_0000, 1'b0, 1'b0, 1'b0}, '{3'd2, 32'hD5FF_0000, 1'b0, 1'b0, 1'b1},
      '{3'd3, 32'hB912_3400, 1'b0, 1'b0, 1'b1}, '{3'd3, 32'hD301_0000, 1'b0, 1'b0, 1'b1},
      '{3'd1, 32'hB100_0000, 1'b0, 1'b1, 1'b1}, '{3'd2, 32'hD403_0000, 1'b1, 1'b0, 1'b1},
      '{3'd2, 32'hD40F_0000, 1'b0, 1'b0, 1'b1}, '{3'd2, 32'hD577_0000, 1'b0, 1'b0, 1'b0},
      '{3'd2, 32'hD5FF_0000, 1'b0, 1'b0, 1'b0}, '{3'd2, 32'hD5FF_0000, 1'b0, 1'b0, 1'b1},
      '{3'd2, 32'hD53C_0000, 1'b0, 1'b0, 1'b1}, '{3'd3, 32'hD300_0000, 1'b0, 1'b0, 1'b1},
      '{3'd2, 32'hD5FF_0000, 1'b0, 1'b0, 1'b0}, '{3'd2, 32'hD53C_0000, 1'b0, 1'b0, 1'b0},
      '{3'd2, 32'hD53C_0000, 1'b0, 1'b0, 1'b1}, '{3'd1, 32'h1200_0000, 1'b0, 1'b0, 1'b1},
      '{3'd2, 32'hD5FF_0000, 1'b0, 1'b0, 1'b1}, '{3'd4, 32'hD301_0007, 1'b1, 1'b0, 1'b1}};
   eew_link_if lk_if ();
   eew_dev eew_dev_inst (.clk(clk), .reset(reset), .lk(lk_if), .int_we(int_we), .int_main(int_main),
      .int_addr(int_addr), .int_wdata(int_wdata), .cfg_ff(cfg_ff), .status_ff(status_ff),
      .first_flag_ff(first_flag_ff));
   eew_host #(.ERASE_WAIT(20)) eew_host_inst (.clk(clk), .reset(reset), .lk(lk_if), .u_valid(u_valid),
      .u_first(u_first), .u_last(u_last), .u_byte(u_byte), .dev_unlocked(status_ff[4]),
      .u_ready_ff(u_ready_ff), .u_nack_ff(u_nack_ff), .u_err_ff(u_err_ff), .u_done_ff(u_done_ff));
   eew_link_properties eew_link_properties_inst (.clk(clk), .reset(reset), .lk_start(lk_if.lk_start),
      .lk_data_stb(lk_if.lk_data_stb), .lk_stop(lk_if.lk_stop), .lk_byte(lk_if.lk_byte),
      .lk_ack(lk_if.lk_ack), .lk_nack(lk_if.lk_nack), .lk_busy(lk_if.lk_busy));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // array images: byte at load step i holds 3(base+i)+1
   function automatic logic [127:0] pat(input int base);
      logic [127:0] e;
      for (int k = 0; k < 16; k++)
         e[8*k +: 8] = 8'(3 * (base + k) + 1);
      return e;
   endfunction
   task automatic finish_test();
      if (miscompares == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask
   task automatic wait_one(inout int w);
      @(negedge clk);
      w++;
      if (w > 3000)
      begin
         miscompares++;
         finish_test();
      end
   endtask
   task automatic wait_idle();
      int w;
      w = 0;
      while (lk_if.lk_busy !== 1'b0)
         wait_one(w);
   endtask
   // offer the queued bytes as one transaction and collect its outcome
   task automatic send();
      int w;
      foreach (bq[i])
      begin
         @(negedge clk);
         u_valid = 1'b1;
         u_first = (i == 0);
         u_last = (i == bq.size() - 1);
         u_byte = bq[i];
         w = 0;
         while (u_ready_ff !== 1'b1)
            wait_one(w);
      end
      @(negedge clk);
      u_valid = 1'b0;
      w = 0;
      while (u_done_ff !== 1'b1 && u_err_ff !== 1'b1)
         wait_one(w);
      nk = u_nack_ff;
      er = u_err_ff;
   endtask
   task automatic send1(input logic [7:0] b);
      bq = '{b};
      send();
   endtask
   task automatic do_reset();
      reset = 1'b1;
      repeat (16) @(negedge clk);
      reset = 1'b0;
      wait_idle();
   endtask
   initial
   begin
      {u_valid, u_first, u_last, u_byte, int_we, int_main, int_addr, int_wdata} = '0;
      miscompares = 0;
      tests_run = 0;
      do_reset();
      // preload pages 0 and 1 and two first flag bytes, then power up again
      for (int i = 0; i < 34; i++)
      begin
         @(negedge clk);
         int_we = 1'b1;
         int_main = (i < 32);
         int_addr = (i < 16) ? 13'(i) : (i < 32) ? 13'(496 + i) : 13'(i - 32);
         int_wdata = 8'(3 * i + 1);
      end
      @(negedge clk);
      int_we = 1'b0;
      do_reset();
      chk("first flag", {8'(3 * 33 + 1), 8'(3 * 32 + 1)}, first_flag_ff);
      chk("cfg", pat(16), cfg_ff);
      chk("status", 8'h00, status_ff);
      foreach (rows[r])
      begin
         bq.delete();
         for (int i = 0; i < rows[r].n; i++)
            bq.push_back(rows[r].by[31 - 8 * i -: 8]);
         send();
         chk("nack", rows[r].nk, nk);
         chk("refused", rows[r].er, er);
         chk("unlocked", rows[r].ul, status_ff[UNLOCK_BIT]);
      end
      chk("cfg", pat(0), cfg_ff);
      // page 15 was erased above, so the block lands on ones at offset 256
      bq = '{8'hBF};
      for (int i = 0; i < 256; i++)
         bq.push_back(8'(i));
      send();
      chk("block nack", 1'b0, nk);
      chk("erased byte", ERASED_BYTE, eew_dev_inst.main_mem[13'h1E00]);
      chk("block byte", 8'h5A, eew_dev_inst.main_mem[13'h1F5A]);
      send1(CMD_RESTORE_USER);
      chk("cfg", pat(16), cfg_ff);
      send1(CMD_RESTORE_FACT);
      do_reset();
      chk("cfg", pat(16), cfg_ff);
      chk("status", 8'h00, status_ff);
      finish_test();
   end
endmodule
